// ---- core/otpp_port.sv ----
// design: slave-side programming port of a one-time-programmable program memory
// Functional notes
// - device is a pure slave; it never starts a transfer.
// - one byte programs within one cycle of about 100 us.
// - mode pins: 00 reserved, 01 signature, 10 lock bits, 11 memory byte.
// - high address bits captured on latch strobe falling edge.
// - read strobe returns memory byte, signature byte or lock bits per mode.
// - write strobe starts memory and lock-bit programming; the cycle length is fixed.
// - address port carries low bits directly and latched high bits.
// - data port is bidirectional: device drives only on reads.
module otpp_port
	import otpp_pkg::*;
(
	// clock and reset
	input  wire logic       SYS_CLK,
	input  wire logic       SYS_RST,
	// mode and strobes, active high
	input  wire logic       BASIC_MODE_SELECT,
	input  wire logic       ACCESS_MODE_SELECT_LO,
	input  wire logic       ACCESS_MODE_SELECT_HI,
	input  wire logic       HIGH_ADDRESS_LATCH_STROBE,
	input  wire logic       OTP_READ_STROBE,
	input  wire logic       OTP_WRITE_STROBE,
	input  wire logic       CODE_FETCH_ENABLE_IN,
	// address port
	input  wire logic [7:0] ADDR_PORT,
	// data port, three signals
	input  wire logic [7:0] DATA_IN,
	output logic      [7:0] DATA_OUT,
	output logic            DATA_OE,
	// status
	output logic            OTP_WRITE_STROBE_BUSY
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	otpp_pins_t         pins;
	otpp_pins_t         prev;
	logic [HI_W-1:0]    addr_hi;
	logic [HI_W-1:0]    next_addr_hi;
	logic [7:0]         mem [MEM_DEPTH];
	logic [LOCK_W-1:0]  lock;
	logic [LOCK_W-1:0]  next_lock;
	otpp_state_t        state;
	otpp_state_t        next_state;
	logic [12:0]        cnt;
	logic [12:0]        next_cnt;
	logic [ADDR_W-1:0]  otp_write_strobe_addr;
	logic [ADDR_W-1:0]  next_otp_write_strobe_addr;
	logic [7:0]         otp_write_strobe_data;
	logic [7:0]         next_otp_write_strobe_data;
	logic               mem_we;
	logic [7:0]         next_mem_byte;
	logic [7:0]         next_data_out;
	logic               next_data_oe;
	logic               active;

	function automatic logic [ADDR_W-1:0] full_addr(input logic [HI_W-1:0] hi, input logic [7:0] lo);
		full_addr = {hi, lo};
	endfunction

	function automatic logic [7:0] sig_byte(input logic [1:0] idx);
		unique case (idx)
			2'h0: sig_byte = SIG_BYTE0;
			2'h1: sig_byte = SIG_BYTE1;
			2'h2: sig_byte = SIG_BYTE2;
			2'h3: sig_byte = SIG_BYTE3;
		endcase
	endfunction

	always_comb begin
		pins.latch = HIGH_ADDRESS_LATCH_STROBE;
		pins.rd    = OTP_READ_STROBE;
		pins.wr    = OTP_WRITE_STROBE;
		// mode is sampled as a pair; programmer keeps it still while latch is high
		pins.mode  = {ACCESS_MODE_SELECT_HI, ACCESS_MODE_SELECT_LO};
		pins.addr  = ADDR_PORT;
		pins.data  = DATA_IN;
	end

	// the port works only in basic mode with fetch enable held low
	assign active = SYS_RST == 1'b0 && BASIC_MODE_SELECT && !CODE_FETCH_ENABLE_IN;

	// ----------------------------------------
	// address latch
	// ----------------------------------------
	// the low bits stay live; only the high 7 bits are held
	always_comb begin
		next_addr_hi = addr_hi;
		if (prev.latch && !pins.latch)
			next_addr_hi = pins.addr[HI_W-1:0];
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			prev    <= '0;
			addr_hi <= '0;
		end else begin
			prev    <= pins;
			addr_hi <= next_addr_hi;
		end
	end

	// ----------------------------------------
	// programming sequencer
	// ----------------------------------------
	// the write strobe rising edge starts one fixed-length cycle; memory bits only clear-to-program, lock bits only set
	always_comb begin
		next_state     = state;
		next_cnt       = cnt;
		next_otp_write_strobe_addr = otp_write_strobe_addr;
		next_otp_write_strobe_data = otp_write_strobe_data;
		next_lock      = lock;
		mem_we         = 1'b0;
		next_mem_byte  = mem[otp_write_strobe_addr] & otp_write_strobe_data; // cells only clear, never set
		unique case (state)
			OTPP_IDLE: begin
				if (active && pins.wr && !prev.wr) begin
					next_otp_write_strobe_addr = full_addr(addr_hi, pins.addr);
					next_otp_write_strobe_data = pins.data;
					next_cnt       = '0;
					if (otpp_mode_t'(pins.mode) == OTPP_MODE_MEM || otpp_mode_t'(pins.mode) == OTPP_MODE_LOCK)
						next_state = OTPP_OTP_WRITE_STROBE;
				end
			end
			OTPP_OTP_WRITE_STROBE: begin
				next_cnt = cnt + 13'h0001;
				if (cnt == OTP_WRITE_STROBE_LAST) begin
					if (otpp_mode_t'(pins.mode) == OTPP_MODE_MEM)
						mem_we = 1'b1;
					else
						next_lock = lock | otp_write_strobe_data[LOCK_W-1:0]; // lock bits only ever set
					next_state = OTPP_WAIT_REL;
				end
			end
			OTPP_WAIT_REL: begin
				if (!pins.wr)
					next_state = OTPP_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state     <= OTPP_IDLE;
			cnt       <= '0;
			otp_write_strobe_addr <= '0;
			otp_write_strobe_data <= '0;
			lock      <= LOCK_RESET;
		end else begin
			state     <= next_state;
			cnt       <= next_cnt;
			otp_write_strobe_addr <= next_otp_write_strobe_addr;
			otp_write_strobe_data <= next_otp_write_strobe_data;
			lock      <= next_lock;
		end
	end

	// ----------------------------------------
	// otp array
	// ----------------------------------------
	// the logic reset stands in for a fresh, erased part; contents
	// do not survive it, unlike a real array
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			for (int i = 0; i < MEM_DEPTH; i++)
				mem[i] <= ERASED_BYTE;
		end else if (mem_we) begin
			mem[otp_write_strobe_addr] <= next_mem_byte;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// no read while a cell is being programmed
	always_comb begin
		next_data_out = '0;
		next_data_oe  = 1'b0;
		if (active && pins.rd && !pins.wr && state == OTPP_IDLE) begin
			unique case (otpp_mode_t'(pins.mode))
				OTPP_MODE_MEM: begin
					next_data_out = mem[full_addr(addr_hi, pins.addr)];
					next_data_oe  = 1'b1;
				end
				OTPP_MODE_LOCK: begin
					next_data_out = {6'h00, lock};
					next_data_oe  = 1'b1;
				end
				OTPP_MODE_SIG: begin
					next_data_out = sig_byte(pins.addr[1:0]);
					next_data_oe  = 1'b1;
				end
				OTPP_MODE_RSVD: begin
					next_data_oe  = 1'b0;
				end
			endcase
		end
	end

	// data outputs fall back to idle one cycle after the read strobe drops
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			DATA_OUT  <= '0;
			DATA_OE   <= 1'b0;
			OTP_WRITE_STROBE_BUSY <= 1'b0;
		end else begin
			DATA_OUT  <= next_data_out;
			DATA_OE   <= next_data_oe;
			OTP_WRITE_STROBE_BUSY <= next_state != OTPP_IDLE;
		end
	end

endmodule

// ---- core/otpp_pkg.sv ----
// package: constants and types for the otp programming port
package otpp_pkg;

	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int ADDR_W     = 15;
	localparam int LO_W       = 8;
	localparam int HI_W       = 7;
	localparam int MEM_DEPTH  = 32768;
	localparam int SIG_DEPTH  = 4;
	localparam int LOCK_W     = 2;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ        = 40000000;
	localparam int OTP_WRITE_STROBE_TIME_US  = 100;
	// longest time rounds down
	localparam int OTP_WRITE_STROBE_CYCLES   = (OTP_WRITE_STROBE_TIME_US * (CLK_HZ / 1000000));
	localparam logic [12:0] OTP_WRITE_STROBE_LAST = 13'(OTP_WRITE_STROBE_CYCLES - 1);

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [1:0] LOCK_RESET  = 2'h0;
	// signature values are arbitrary
	localparam logic [7:0] SIG_BYTE0 = 8'h5a;
	localparam logic [7:0] SIG_BYTE1 = 8'h3c;
	localparam logic [7:0] SIG_BYTE2 = 8'h11;
	localparam logic [7:0] SIG_BYTE3 = 8'h01;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		OTPP_MODE_RSVD = 2'h0,
		OTPP_MODE_SIG  = 2'h1,
		OTPP_MODE_LOCK = 2'h2,
		OTPP_MODE_MEM  = 2'h3
	} otpp_mode_t;

	typedef enum {OTPP_IDLE, OTPP_OTP_WRITE_STROBE, OTPP_WAIT_REL} otpp_state_t;

	typedef struct packed {
		logic       latch;
		logic       rd;
		logic       wr;
		logic [1:0] mode;
		logic [7:0] addr;
		logic [7:0] data;
	} otpp_pins_t;

endpackage

// ---- tb/otpp_port_monitor.sv ----
// checker: timing and value relations on the programming port pins
module otpp_port_monitor
	import otpp_pkg::*;
(
	input wire logic       SYS_CLK,
	input wire logic       SYS_RST,
	input wire logic       BASIC_MODE_SELECT,
	input wire logic       ACCESS_MODE_SELECT_LO,
	input wire logic       ACCESS_MODE_SELECT_HI,
	input wire logic       OTP_READ_STROBE,
	input wire logic       OTP_WRITE_STROBE,
	input wire logic       CODE_FETCH_ENABLE_IN,
	input wire logic [7:0] DATA_OUT,
	input wire logic       DATA_OE,
	input wire logic       OTP_WRITE_STROBE_BUSY
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	wire  [1:0]  mode = {ACCESS_MODE_SELECT_HI, ACCESS_MODE_SELECT_LO};
	wire         act  = BASIC_MODE_SELECT && !CODE_FETCH_ENABLE_IN && !OTP_WRITE_STROBE_BUSY;
	wire         rd   = act && OTP_READ_STROBE && !OTP_WRITE_STROBE;
	// busy run length, to bound the program time both ways
	always_comb next_cnt = OTP_WRITE_STROBE_BUSY ? cnt + 16'h1 : 16'h0;
	always_ff @(posedge SYS_CLK or posedge SYS_RST)
		if (SYS_RST)
			cnt <= 16'h0;
		else
			cnt <= next_cnt;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	a_rsvd_idle: assert property (mode == 2'h0 |=> !DATA_OE) else $error("reserved drive");
	a_read_answer: assert property (rd && mode != 2'h0 |=> DATA_OE) else $error("read lost");
	a_port_release: assert property (!OTP_READ_STROBE |=> !DATA_OE) else $error("stray drive");
	a_busy_refuse: assert property (OTP_WRITE_STROBE_BUSY |=> !DATA_OE) else $error("read in busy");
	a_lock_upper: assert property (rd && mode == 2'h2 |=> DATA_OUT[7:2] == 6'h0) else $error("lock bits");
	a_write_start: assert property (act && mode[1] && $rose(OTP_WRITE_STROBE) |=> OTP_WRITE_STROBE_BUSY) else $error("no start");
	a_otp_write_strobe_min: assert property ($fell(OTP_WRITE_STROBE_BUSY) |-> cnt >= 16'(OTP_WRITE_STROBE_CYCLES)) else $error("short cycle");
	a_otp_write_strobe_max: assert property (cnt > 16'(OTP_WRITE_STROBE_CYCLES + 4) && !OTP_WRITE_STROBE |=> !OTP_WRITE_STROBE_BUSY) else $error("long cycle");
	c_otp_write_strobe: cover property ($fell(OTP_WRITE_STROBE_BUSY));
	c_lock: cover property (rd && mode == 2'h2);
	c_rsvd: cover property (mode == 2'h0 && OTP_READ_STROBE);
endmodule

// ---- tb/otpp_programmer.sv ----
// partner: programmer side of the shared data lines
module otpp_programmer (
	input  wire logic       clk,
	input  wire logic       drive,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] dev_data,
	input  wire logic       dev_oe,
	output logic      [7:0] bus
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last = 8'h0;
	// floating lines toggle so a stale byte never looks valid
	always_comb bus = drive ? wdata : (dev_oe ? dev_data : ~last);
	always_ff @(posedge clk) last <= bus;
endmodule

// ---- tb/test_otpp_port.sv ----
// testbench: directed scenarios for the otp programming port
module test_otpp_port
	import otpp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       basic = 1'b0;
	logic       cfe = 1'b0;
	logic       drv = 1'b0;
	otpp_pins_t p = 21'h0;
	wire  [7:0] bus;
	wire  [7:0] dout;
	wire        oe;
	wire        busy;
	int         mismatches = 0;
	int         checked = 0;
	otpp_port i_dut (.SYS_CLK(clk), .SYS_RST(rst), .BASIC_MODE_SELECT(basic),
		.ACCESS_MODE_SELECT_LO(p.mode[0]), .ACCESS_MODE_SELECT_HI(p.mode[1]), .HIGH_ADDRESS_LATCH_STROBE(p.latch),
		.OTP_READ_STROBE(p.rd), .OTP_WRITE_STROBE(p.wr), .CODE_FETCH_ENABLE_IN(cfe), .ADDR_PORT(p.addr),
		.DATA_IN(bus), .DATA_OUT(dout), .DATA_OE(oe), .OTP_WRITE_STROBE_BUSY(busy));
	otpp_programmer i_otp_write_strobe (.clk(clk), .drive(drv), .wdata(p.data), .dev_data(dout), .dev_oe(oe), .bus(bus));
	initial forever #12.5 clk = ~clk;
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_cnt(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask
	// mode moves only while the latch strobe is low
	task automatic setup(input logic [1:0] m, input logic [7:0] hi);
		p.mode <= m;
		p.addr <= hi;
		step(1);
		p.latch <= 1'b1;
		step(1);
		p.latch <= 1'b0;
		step(1);
	endtask
	task automatic rd(input logic [7:0] lo, input logic [7:0] exp, input logic en);
		p.addr <= lo;
		p.rd <= 1'b1;
		step(1);
		@(negedge clk);
		cmp({7'h0, oe}, {7'h0, en});
		if (en) cmp(dout, exp);
		step(1);
		p.rd <= 1'b0;
		step(2);
	endtask
	task automatic wr(input logic [7:0] lo, input logic [7:0] d, input logic en);
		p.addr <= lo;
		p.data <= d;
		drv <= 1'b1;
		p.wr <= 1'b1;
		step(1);
		@(negedge clk);
		cmp({7'h0, busy}, {7'h0, en});
		step(1);
		if (en) step(OTP_WRITE_STROBE_CYCLES + 4);
		p.wr <= 1'b0;
		drv <= 1'b0;
		step(1);
		@(negedge clk);
		cmp({7'h0, busy}, 8'h0);
		step(1);
	endtask
	// short strobe: the cycle still runs to its end on its own
	task automatic wr_time(input logic [7:0] lo, input logic [7:0] d);
		logic [15:0] n;
		n = 16'h2;
		p.addr <= lo;
		p.data <= d;
		drv <= 1'b1;
		p.wr <= 1'b1;
		step(2);
		p.wr <= 1'b0;
		drv <= 1'b0;
		do begin
			step(1);
			@(negedge clk);
			n++;
		end while (busy !== 1'b0 && n < 16'(2 * OTP_WRITE_STROBE_CYCLES));
		cmp_cnt(n, 16'(OTP_WRITE_STROBE_CYCLES + 2));
		step(1);
	endtask
	task automatic t_sig_rsvd();
		setup(2'h1, 8'h0);
		rd(8'h0, SIG_BYTE0, 1'b1);
		rd(8'h3, SIG_BYTE3, 1'b1);
		wr(8'h0, 8'h00, 1'b0);
		setup(2'h0, 8'h0);
		rd(8'h0, 8'h00, 1'b0);
		wr(8'h0, 8'h00, 1'b0);
	endtask
	task automatic t_mem();
		setup(2'h3, 8'h55);
		wr(8'ha3, 8'h3c, 1'b1);
		setup(2'h3, 8'h2a);
		wr(8'ha3, 8'hc5, 1'b1);
		wr(8'ha3, 8'h0f, 1'b1);
		rd(8'ha3, 8'h05, 1'b1);
		setup(2'h3, 8'h55);
		rd(8'ha3, 8'h3c, 1'b1);
		cfe <= 1'b1;
		rd(8'ha3, 8'h00, 1'b0);
		cfe <= 1'b0;
		wr_time(8'ha3, 8'h96);
		rd(8'ha3, 8'h14, 1'b1);
	endtask
	task automatic t_lock();
		setup(2'h2, 8'h0);
		rd(8'h0, 8'h00, 1'b1);
		wr(8'h0, 8'h02, 1'b1);
		wr(8'h0, 8'h01, 1'b1);
		rd(8'h0, 8'h03, 1'b1);
	endtask
	task automatic summarize();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		step(6);
		rst <= 1'b0;
		basic <= 1'b1;
		step(2);
		t_sig_rsvd();
		t_mem();
		t_lock();
		summarize();
	end
endmodule
bind otpp_port otpp_port_monitor i_mon (.*);
